// >>> tacq_chk.sv
// port-level assertions for the touch acquisition config block
`timescale 1ns/1ns
module tacq_chk
(
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    // watched ports
    input wire logic        i_rd_en,
    input wire logic [31:0] o_rd_data,
    input wire logic        i_at_valid,
    input wire logic [15:0] i_at_signal,
    input wire logic [15:0] i_at_reference,
    input wire logic        o_recal_req,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_discharge,
    input wire logic        o_charge,
    input wire logic        o_settle,
    input wire logic        o_cx_discharge,
    input wire logic        o_spread,
    input wire logic        o_comp_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // read data only stands in the answer cycle
    rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0000_0000)
        else $error("read data outside answer cycle");
    // recalibration needs a valid sample above the reference
    recal_cause_a: assert property (o_recal_req |-> $past(i_at_valid)
        && $past(i_at_signal) > $past(i_at_reference)) else $error("recal without rise");
    done_end_a: assert property (o_done |-> !o_busy && $past(o_busy))
        else $error("done without a finished run");
    comp_on_a: assert property (o_busy && $past(o_busy) |-> o_comp_enable)
        else $error("comparator off while busy");
    spread_busy_a: assert property (o_spread |-> o_busy || o_done)
        else $error("spread drive while idle");
    // phase order: discharge opens, settle follows charge, cx follows settle
    disch_first_a: assert property ($rose(o_discharge) |-> $past(o_busy)
        && !$past(o_charge || o_settle)) else $error("discharge not at start");
    settle_after_a: assert property ($rose(o_settle) |-> $past(o_charge))
        else $error("settle not after charge");
    cx_after_a: assert property ($rose(o_cx_discharge) |-> $past(o_settle))
        else $error("cx discharge not after settle");
endmodule

bind tacq_top tacq_chk chk
(
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_at_valid(i_at_valid), .i_at_signal(i_at_signal), .i_at_reference(i_at_reference),
    .o_recal_req(o_recal_req), .o_busy(o_busy), .o_done(o_done), .o_charge(o_charge),
    .o_discharge(o_discharge), .o_settle(o_settle), .o_cx_discharge(o_cx_discharge),
    .o_spread(o_spread), .o_comp_enable(o_comp_enable)
);

// >>> tacq_electrode.sv
// electrode and comparator model: trips after a set number of charge bursts
`timescale 1ns/1ns
module tacq_electrode
(
    // clock and sequencer phases
    input  wire logic        i_clk,
    input  wire logic        i_busy,
    input  wire logic        i_charge,
    // bursts before the comparator trips, zero never trips
    input  wire logic [15:0] i_trip,
    output logic             o_comp
);
    int   bursts = 0;
    logic chg_q  = 1'b0;
    // charge builds only within one acquisition
    always_ff @(posedge i_clk)
    begin
        chg_q <= i_charge;
        bursts <= !i_busy ? 0 : bursts + int'(i_charge && !chg_q);
    end
    // comparator goes positive once enough charge has moved
    assign o_comp = (i_trip != 16'h0000) && (bursts >= int'(i_trip));
endmodule

// >>> tacq_params.svh
// register map, field positions and reset values of the touch acquisition config block
`ifndef TACQ_PARAMS_SVH
`define TACQ_PARAMS_SVH

// byte addresses of the registers
`define TACQ_ADDR_DRIFT     8'h1c
`define TACQ_ADDR_TGA_TIM   8'h20
`define TACQ_ADDR_TGA_DIS   8'h24
`define TACQ_ADDR_TGB_TIM   8'h28
`define TACQ_ADDR_TGB_DIS   8'h2c
`define TACQ_ADDR_MG_TIM    8'h30
`define TACQ_ADDR_MG_DIS    8'h34
`define TACQ_ADDR_MG_FILT   8'h38
`define TACQ_ADDR_STATUS    8'h60

// reset values
`define TACQ_REG_RST        32'h0000_0000
`define TACQ_RD_NONE        32'h0000_0000
`define TACQ_LFSR_SEED      8'h01

// configuration slots inside the register array
`define TACQ_SLOT_DRIFT     0
`define TACQ_SLOT_MG_FILT   7

// drift register fields
`define TACQ_POSITIVE_RECAL_THRESHOLD_HI        23
`define TACQ_POSITIVE_RECAL_THRESHOLD_LO        16
`define TACQ_POSITIVE_DRIFT_INTERVAL_HI      15
`define TACQ_POSITIVE_DRIFT_INTERVAL_LO      8
`define TACQ_NEGATIVE_DRIFT_INTERVAL_HI      7
`define TACQ_NEGATIVE_DRIFT_INTERVAL_LO      0
`define TACQ_DRIFT_UNIT     16'h0000

// timing register fields
`define TACQ_DIV_HI         31
`define TACQ_DIV_LO         16
`define TACQ_CHARGE_LENGTH_HI       15
`define TACQ_CHARGE_LENGTH_LO       8
`define TACQ_SETTLE_LENGTH_HI       7
`define TACQ_SETTLE_LENGTH_LO       0

// discharge register fields
`define TACQ_DISCHARGE_SHIFT_HI     29
`define TACQ_DISCHARGE_SHIFT_LO     28
`define TACQ_SYNC_BIT       25
`define TACQ_SPREAD_BIT     24
`define TACQ_DISCHARGE_LENGTH_HI       23
`define TACQ_DISCHARGE_LENGTH_LO       16
`define TACQ_MAX_HI         15
`define TACQ_MAX_LO         0

// matrix filter register fields
`define TACQ_COMPARATOR_POWER_CONTROL_BIT     31
`define TACQ_CONSENSUS_FILTER_LENGTH_HI      30
`define TACQ_CONSENSUS_FILTER_LENGTH_LO      28
`define TACQ_CXDIL_HI       23
`define TACQ_CXDIL_LO       16
`define TACQ_XLINE_START_INTERVAL_HI     11
`define TACQ_XLINE_START_INTERVAL_LO     0

// group selection codes
`define TACQ_GRP_A          2'h0
`define TACQ_GRP_B          2'h1
`define TACQ_GRP_M          2'h2
`define TACQ_GRP_BAD        2'h3

// small constants
`define TACQ_ONE16          16'h0001
`define TACQ_ONE24          24'h00_0001
`define TACQ_ONE12          12'h001
`define TACQ_SAT12          12'hfff
`define TACQ_PAD8           8'h00

`endif

// >>> tacq_pkg.sv
// types shared by the touch acquisition config block
package tacq_pkg;

    // acquisition sequencer states
    typedef enum logic [2:0]
    {
        TACQ_IDLE,
        TACQ_HOLD,
        TACQ_DISCH,
        TACQ_CHARGE,
        TACQ_SETTLE,
        TACQ_CXDIS
    } tacq_state_t;

    // whole state of the block
    typedef struct packed
    {
        logic [7:0][31:0] cfg;
        logic [31:0]      rd_data;
        logic [2:0][15:0] pre_cnt;
        logic [2:0]       pre_clk;
        logic [2:0]       tick;
        logic [7:0]       lfsr;
        tacq_state_t      st;
        logic [1:0]       grp;
        logic [15:0]      ph_cnt;
        logic [15:0]      count;
        logic [4:0]       cons;
        logic             sync_prev;
        logic [11:0]      xl_cnt;
        logic [23:0]      pd_cnt;
        logic [23:0]      nd_cnt;
        logic             pos_drift;
        logic             neg_drift;
        logic             recal;
        logic             done;
        logic             max_hit;
        logic             busy;
        logic             ph_dis;
        logic             ph_chg;
        logic             ph_set;
        logic             ph_cxd;
        logic             spread;
        logic             comp_en;
    } tacq_state_s_t;

endpackage

// >>> tacq_top.sv
// touch acquisition config block: registers, prescalers, drift timers and burst sequencer
`timescale 1ns/1ns
`include "tacq_params.svh"

module tacq_top
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    output logic      [31:0] o_rd_data,
    // acquisition request and analog front end
    input  wire logic        i_acq_start,
    input  wire logic [1:0]  i_acq_sel,
    input  wire logic        i_sync,
    input  wire logic        i_comp,
    // autonomous sensor measurements
    input  wire logic        i_at_sample_tick,
    input  wire logic        i_at_valid,
    input  wire logic [15:0] i_at_signal,
    input  wire logic [15:0] i_at_reference,
    // derived clocks and sequencer outputs
    output logic      [2:0]  o_grp_clk,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_max_hit,
    output logic      [15:0] o_count,
    output logic             o_discharge,
    output logic             o_charge,
    output logic             o_settle,
    output logic             o_cx_discharge,
    output logic             o_spread,
    output logic             o_comp_enable,
    // drift and recalibration events
    output logic             o_recal_req,
    output logic             o_pos_drift,
    output logic             o_neg_drift
);

    tacq_pkg::tacq_state_s_t s_q;
    tacq_pkg::tacq_state_s_t s_d;

    // fields of the group that the sequencer serves
    logic [31:0] tim_w;
    logic [31:0] dis_w;
    logic [31:0] flt_w;
    logic        gtick_w;
    logic        step_w;
    logic [15:0] dis_len_w;
    logic [2:0]  cons_sum_w;
    logic        term_w;
    logic        sync_ok_w;
    logic        xl_ok_w;
    logic [16:0] at_limit_w;
    logic [15:0] div_w;
    logic [15:0] lim_w;
    logic [15:0] next_cnt_w;

    // next-state logic of the whole block
    always_comb
    begin
        s_d = s_q;
        tim_w = '0;
        dis_w = '0;
        flt_w = '0;
        gtick_w = 1'b0;
        step_w = 1'b0;
        dis_len_w = '0;
        cons_sum_w = '0;
        term_w = 1'b0;
        sync_ok_w = 1'b0;
        xl_ok_w = 1'b0;
        at_limit_w = '0;
        div_w = '0;
        lim_w = '0;
        next_cnt_w = '0;
        s_d.tick = '0;
        s_d.done = 1'b0;
        s_d.recal = 1'b0;
        s_d.pos_drift = 1'b0;
        s_d.neg_drift = 1'b0;

        // register writes
        if (i_wr_en)
        begin
            case (i_addr)
                `TACQ_ADDR_DRIFT:   s_d.cfg[0] = i_wr_data;
                `TACQ_ADDR_TGA_TIM: s_d.cfg[1] = i_wr_data;
                `TACQ_ADDR_TGA_DIS: s_d.cfg[2] = i_wr_data;
                `TACQ_ADDR_TGB_TIM: s_d.cfg[3] = i_wr_data;
                `TACQ_ADDR_TGB_DIS: s_d.cfg[4] = i_wr_data;
                `TACQ_ADDR_MG_TIM:  s_d.cfg[5] = i_wr_data;
                `TACQ_ADDR_MG_DIS:  s_d.cfg[6] = i_wr_data;
                `TACQ_ADDR_MG_FILT: s_d.cfg[7] = i_wr_data;
                default:            s_d.cfg = s_q.cfg;
            endcase
        end

        // read data valid only in the cycle after the strobe; unmapped reads zero
        s_d.rd_data = `TACQ_RD_NONE;
        if (i_rd_en)
        begin
            case (i_addr)
                `TACQ_ADDR_DRIFT:   s_d.rd_data = s_q.cfg[0];
                `TACQ_ADDR_TGA_TIM: s_d.rd_data = s_q.cfg[1];
                `TACQ_ADDR_TGA_DIS: s_d.rd_data = s_q.cfg[2];
                `TACQ_ADDR_TGB_TIM: s_d.rd_data = s_q.cfg[3];
                `TACQ_ADDR_TGB_DIS: s_d.rd_data = s_q.cfg[4];
                `TACQ_ADDR_MG_TIM:  s_d.rd_data = s_q.cfg[5];
                `TACQ_ADDR_MG_DIS:  s_d.rd_data = s_q.cfg[6];
                `TACQ_ADDR_MG_FILT: s_d.rd_data = s_q.cfg[7];
                `TACQ_ADDR_STATUS:  s_d.rd_data = {s_q.count, `TACQ_PAD8, 1'b0, s_q.st,
                                                   s_q.grp, s_q.max_hit, s_q.busy};
                default:            s_d.rd_data = `TACQ_RD_NONE;
            endcase
        end

        // spread-spectrum jitter source, free running
        s_d.lfsr = {s_q.lfsr[6:0], s_q.lfsr[7] ^ s_q.lfsr[5] ^ s_q.lfsr[4] ^ s_q.lfsr[3]};

        // prescalers: half period of div+1 clocks, tick once per full period
        for (int g = 0; g < 3; g++)
        begin
            div_w = s_q.cfg[2 * g + 1][`TACQ_DIV_HI:`TACQ_DIV_LO];
            lim_w = div_w;
            if (s_q.cfg[2 * g + 2][`TACQ_SPREAD_BIT] && s_q.busy && (s_q.grp == 2'(g)))
            begin
                lim_w = div_w ^ {14'h0000, s_q.lfsr[1:0]};
            end
            if (s_q.pre_cnt[g] >= lim_w)
            begin
                s_d.pre_cnt[g] = '0;
                s_d.pre_clk[g] = ~s_q.pre_clk[g];
                s_d.tick[g] = ~s_q.pre_clk[g];
            end
            else
            begin
                s_d.pre_cnt[g] = s_q.pre_cnt[g] + `TACQ_ONE16;
            end
        end

        // recalibration request on a positive excursion past the threshold
        at_limit_w = {1'b0, i_at_reference}
                   + {9'h000, s_q.cfg[`TACQ_SLOT_DRIFT][`TACQ_POSITIVE_RECAL_THRESHOLD_HI:`TACQ_POSITIVE_RECAL_THRESHOLD_LO]};
        if (i_at_valid && ({1'b0, i_at_signal} > at_limit_w))
        begin
            s_d.recal = 1'b1;
        end

        // drift timers count autonomous sample ticks; a zero field parks them
        if (s_q.cfg[`TACQ_SLOT_DRIFT][`TACQ_POSITIVE_DRIFT_INTERVAL_HI:`TACQ_POSITIVE_DRIFT_INTERVAL_LO] == '0)
        begin
            s_d.pd_cnt = '0;
        end
        else if (i_at_sample_tick)
        begin
            if ((s_q.pd_cnt + `TACQ_ONE24) >=
                {s_q.cfg[`TACQ_SLOT_DRIFT][`TACQ_POSITIVE_DRIFT_INTERVAL_HI:`TACQ_POSITIVE_DRIFT_INTERVAL_LO], `TACQ_DRIFT_UNIT})
            begin
                s_d.pd_cnt = '0;
                s_d.pos_drift = 1'b1;
            end
            else
            begin
                s_d.pd_cnt = s_q.pd_cnt + `TACQ_ONE24;
            end
        end
        if (s_q.cfg[`TACQ_SLOT_DRIFT][`TACQ_NEGATIVE_DRIFT_INTERVAL_HI:`TACQ_NEGATIVE_DRIFT_INTERVAL_LO] == '0)
        begin
            s_d.nd_cnt = '0;
        end
        else if (i_at_sample_tick)
        begin
            if ((s_q.nd_cnt + `TACQ_ONE24) >=
                {s_q.cfg[`TACQ_SLOT_DRIFT][`TACQ_NEGATIVE_DRIFT_INTERVAL_HI:`TACQ_NEGATIVE_DRIFT_INTERVAL_LO], `TACQ_DRIFT_UNIT})
            begin
                s_d.nd_cnt = '0;
                s_d.neg_drift = 1'b1;
            end
            else
            begin
                s_d.nd_cnt = s_q.nd_cnt + `TACQ_ONE24;
            end
        end

        // selected group configuration; grp never holds the undefined code
        tim_w = s_q.cfg[2 * s_q.grp + 1];
        dis_w = s_q.cfg[2 * s_q.grp + 2];
        flt_w = s_q.cfg[`TACQ_SLOT_MG_FILT];
        gtick_w = s_q.tick[s_q.grp];
        dis_len_w = 16'({8'h00, dis_w[`TACQ_DISCHARGE_LENGTH_HI:`TACQ_DISCHARGE_LENGTH_LO]}
                        << dis_w[`TACQ_DISCHARGE_SHIFT_HI:`TACQ_DISCHARGE_SHIFT_LO]);
        // self-capacitance discharge counts module clocks, matrix counts burst ticks
        step_w = (s_q.grp == `TACQ_GRP_M) ? gtick_w : 1'b1;

        // interval counter since the last X line start, in burst ticks
        if (s_q.tick[`TACQ_GRP_M] && (s_q.xl_cnt != `TACQ_SAT12))
        begin
            s_d.xl_cnt = s_q.xl_cnt + `TACQ_ONE12;
        end

        // consensus over the last five comparator samples
        cons_sum_w = 3'(s_q.cons[0]) + 3'(s_q.cons[1]) + 3'(s_q.cons[2])
                   + 3'(s_q.cons[3]) + 3'(s_q.cons[4]);
        if (flt_w[`TACQ_CONSENSUS_FILTER_LENGTH_HI:`TACQ_CONSENSUS_FILTER_LENGTH_LO] == '0)
        begin
            term_w = i_comp;
        end
        else
        begin
            term_w = cons_sum_w >= flt_w[`TACQ_CONSENSUS_FILTER_LENGTH_HI:`TACQ_CONSENSUS_FILTER_LENGTH_LO];
        end

        // start gating: sync falling edge and X line spacing
        sync_ok_w = !dis_w[`TACQ_SYNC_BIT] || (s_q.sync_prev && !i_sync);
        xl_ok_w = (s_q.grp != `TACQ_GRP_M)
               || (flt_w[`TACQ_XLINE_START_INTERVAL_HI:`TACQ_XLINE_START_INTERVAL_LO] == '0)
               || (s_q.xl_cnt >= flt_w[`TACQ_XLINE_START_INTERVAL_HI:`TACQ_XLINE_START_INTERVAL_LO]);
        s_d.sync_prev = i_sync;
        next_cnt_w = s_q.count + `TACQ_ONE16;

        // burst sequencer
        case (s_q.st)
            tacq_pkg::TACQ_IDLE:
            begin
                // the undefined selection code is ignored
                if (i_acq_start && (i_acq_sel != `TACQ_GRP_BAD))
                begin
                    s_d.grp = i_acq_sel;
                    s_d.count = '0;
                    s_d.cons = '0;
                    s_d.ph_cnt = '0;
                    s_d.max_hit = 1'b0;
                    s_d.st = tacq_pkg::TACQ_HOLD;
                end
            end
            tacq_pkg::TACQ_HOLD:
            begin
                if (sync_ok_w && xl_ok_w)
                begin
                    if (s_q.grp == `TACQ_GRP_M)
                    begin
                        s_d.xl_cnt = '0;
                    end
                    s_d.ph_cnt = '0;
                    s_d.st = tacq_pkg::TACQ_DISCH;
                end
            end
            tacq_pkg::TACQ_DISCH:
            begin
                if (s_q.ph_cnt >= dis_len_w)
                begin
                    s_d.ph_cnt = '0;
                    s_d.st = tacq_pkg::TACQ_CHARGE;
                end
                else if (step_w)
                begin
                    s_d.ph_cnt = s_q.ph_cnt + `TACQ_ONE16;
                end
            end
            tacq_pkg::TACQ_CHARGE:
            begin
                if (s_q.ph_cnt >= {8'h00, tim_w[`TACQ_CHARGE_LENGTH_HI:`TACQ_CHARGE_LENGTH_LO]})
                begin
                    s_d.ph_cnt = '0;
                    s_d.st = tacq_pkg::TACQ_SETTLE;
                end
                else if (gtick_w)
                begin
                    s_d.ph_cnt = s_q.ph_cnt + `TACQ_ONE16;
                end
            end
            tacq_pkg::TACQ_SETTLE:
            begin
                if (s_q.ph_cnt >= {8'h00, tim_w[`TACQ_SETTLE_LENGTH_HI:`TACQ_SETTLE_LENGTH_LO]})
                begin
                    s_d.ph_cnt = '0;
                    s_d.count = next_cnt_w;
                    if (s_q.grp == `TACQ_GRP_M)
                    begin
                        s_d.st = tacq_pkg::TACQ_CXDIS;
                    end
                    else if (i_comp || (next_cnt_w >= dis_w[`TACQ_MAX_HI:`TACQ_MAX_LO]))
                    begin
                        s_d.max_hit = !i_comp;
                        s_d.done = 1'b1;
                        s_d.st = tacq_pkg::TACQ_IDLE;
                    end
                    else
                    begin
                        s_d.st = tacq_pkg::TACQ_CHARGE;
                    end
                end
                else if (gtick_w)
                begin
                    s_d.ph_cnt = s_q.ph_cnt + `TACQ_ONE16;
                end
            end
            tacq_pkg::TACQ_CXDIS:
            begin
                if (gtick_w)
                begin
                    s_d.cons = {s_q.cons[3:0], i_comp};
                end
                if (term_w)
                begin
                    s_d.done = 1'b1;
                    s_d.st = tacq_pkg::TACQ_IDLE;
                end
                else if (s_q.ph_cnt >= {8'h00, flt_w[`TACQ_CXDIL_HI:`TACQ_CXDIL_LO]})
                begin
                    s_d.ph_cnt = '0;
                    if (s_q.count >= dis_w[`TACQ_MAX_HI:`TACQ_MAX_LO])
                    begin
                        s_d.max_hit = 1'b1;
                        s_d.done = 1'b1;
                        s_d.st = tacq_pkg::TACQ_IDLE;
                    end
                    else
                    begin
                        s_d.st = tacq_pkg::TACQ_CHARGE;
                    end
                end
                else if (gtick_w)
                begin
                    s_d.ph_cnt = s_q.ph_cnt + `TACQ_ONE16;
                end
            end
            default:
            begin
                s_d.st = tacq_pkg::TACQ_IDLE;
            end
        endcase

        // registered copies of the phase decode so outputs come from flops
        s_d.busy = s_d.st != tacq_pkg::TACQ_IDLE;
        s_d.ph_dis = s_d.st == tacq_pkg::TACQ_DISCH;
        s_d.ph_chg = s_d.st == tacq_pkg::TACQ_CHARGE;
        s_d.ph_set = s_d.st == tacq_pkg::TACQ_SETTLE;
        s_d.ph_cxd = s_d.st == tacq_pkg::TACQ_CXDIS;
        s_d.spread = s_d.busy && s_d.cfg[2 * s_d.grp + 2][`TACQ_SPREAD_BIT];
        // comparators only switched off while idle, so no burst ever loses them
        s_d.comp_en = !s_d.cfg[`TACQ_SLOT_MG_FILT][`TACQ_COMPARATOR_POWER_CONTROL_BIT] || s_d.busy;
    end

    // single state register, synchronous reset
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            s_q <= '0;
            s_q.cfg <= {8{`TACQ_REG_RST}};
            s_q.lfsr <= `TACQ_LFSR_SEED;
            s_q.st <= tacq_pkg::TACQ_IDLE;
            s_q.comp_en <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign o_rd_data = s_q.rd_data;
    assign o_grp_clk = s_q.pre_clk;
    assign o_busy = s_q.busy;
    assign o_done = s_q.done;
    assign o_max_hit = s_q.max_hit;
    assign o_count = s_q.count;
    assign o_discharge = s_q.ph_dis;
    assign o_charge = s_q.ph_chg;
    assign o_settle = s_q.ph_set;
    assign o_cx_discharge = s_q.ph_cxd;
    assign o_spread = s_q.spread;
    assign o_comp_enable = s_q.comp_en;
    assign o_recal_req = s_q.recal;
    assign o_pos_drift = s_q.pos_drift;
    assign o_neg_drift = s_q.neg_drift;

endmodule

// >>> touch_acquisition_config_test.sv
// self-checking bench of the touch acquisition config block
`timescale 1ns/1ns
module touch_acquisition_config_test;
    // driven inputs
    logic        i_clk = 0, i_rst_n = 0, i_wr_en = 0, i_rd_en = 0;
    logic        i_acq_start = 0, i_sync = 0, i_at_sample_tick = 0, i_at_valid = 0;
    logic [1:0]  i_acq_sel = '0;
    logic [7:0]  i_addr = '0;
    logic [31:0] i_wr_data = '0;
    logic [15:0] i_at_signal = '0, i_at_reference = '0, trip = '0;
    // design outputs and model
    logic        i_comp, o_busy, o_done, o_max_hit, o_discharge, o_charge, o_settle;
    logic        o_cx_discharge, o_spread, o_comp_enable, o_recal_req, o_pos_drift, o_neg_drift;
    logic [2:0]  o_grp_clk;
    logic [15:0] o_count;
    logic [31:0] o_rd_data, regs [8] = '{default: '0};
    int          n_errors = 0, compares = 0, seed, i, n, k, r, dst;
    int          trips [4] = '{3, 0, 5, 2};

    tacq_top dut (.*);
    tacq_electrode sense (.i_clk(i_clk), .i_busy(o_busy), .i_charge(o_charge),
                          .i_trip(trip), .o_comp(i_comp));
    // 20 MHz module clock
    always #25 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one settled cycle; a runaway wait ends the run
    task automatic cyc();
        @(posedge i_clk);
        #1 n++;
        if (n > 70000)
        begin
            n_errors++;
            summarize();
        end
    endtask
    // register port master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr_en <= 1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 0;
        if (a >= 8'h1c && a <= 8'h38)
            regs[(a - 8'h1c) >> 2] = d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd_en <= 1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 0;
        #1 chk(o_rd_data, (a >= 8'h1c && a <= 8'h38) ? regs[(a - 8'h1c) >> 2] : 32'h0);
    endtask
    // full derived clock period, rising to rising
    task automatic period(input int b);
        n = 0;
        while (o_grp_clk[b] !== 1'b0) cyc();
        while (o_grp_clk[b] !== 1'b1) cyc();
        r = n;
        while (o_grp_clk[b] !== 1'b0) cyc();
        while (o_grp_clk[b] !== 1'b1) cyc();
        k = 2 * (int'(regs[1 + 2 * b][31:16]) + 1);
        rng(n - r, k, k);
    endtask
    // one acquisition, expectations from the register model
    task automatic acq(input int g, input int tr);
        int d, s, m, p, l, met, q;
        d = 0;
        s = 0;
        m = int'(regs[2 + 2 * g][15:0]);
        p = (g == 2) ? 2 * (int'(regs[5][31:16]) + 1) : 1;
        q = p;
        // spread jitter moves each burst half period by up to three clocks either way
        if (g == 2 && regs[6][24])
        begin
            q = 2 * (int'(regs[5][31:16] & 16'hfffc) + 1);
            p = 2 * (int'(regs[5][31:16] | 16'h0003) + 1);
        end
        l = int'(regs[2 + 2 * g][23:16]) << regs[2 + 2 * g][29:28];
        met = int'(tr != 0 && tr <= m && (g != 2 || regs[7][30:28] <= 3'h5));
        @(posedge i_clk);
        trip <= 16'(tr);
        i_sync <= regs[2 + 2 * g][25];
        i_acq_sel <= 2'(g);
        i_acq_start <= 1;
        @(posedge i_clk);
        i_acq_start <= 0;
        n = 0;
        if (regs[2 + 2 * g][25])
        begin
            repeat (12) cyc();
            chk({o_busy, o_discharge}, 32'h0000_0002);
            @(posedge i_clk);
            i_sync <= 0;
        end
        while (o_done !== 1'b1)
        begin
            cyc();
            if (o_discharge === 1'b1 && d == 0) dst = int'($time / 50);
            d += int'(o_discharge === 1'b1);
            s |= int'(o_spread === 1'b1);
        end
        rng(d, l * q - 1, l * p + p);
        chk(s, regs[2 + 2 * g][24]);
        chk(o_count, met ? tr : m);
        chk(o_max_hit, !met);
    endtask

    initial
    begin
        seed = $urandom(18813);
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1;
        #1 chk(o_comp_enable, 32'h0000_0001);
        // reset values, random read-back, unmapped 0x3c
        for (i = 0; i < 9; i++) rd(8'h1c + 8'(i * 4));
        for (i = 0; i < 9; i++) wr(8'h1c + 8'(i * 4), $urandom);
        for (i = 0; i < 9; i++) rd(8'h1c + 8'(i * 4));
        wr(8'h38, 32'h8000_0000);
        n = 0;
        repeat (3) cyc();
        chk(o_comp_enable, 32'h0000_0000);
        wr(8'h20, 32'h0001_0201);
        wr(8'h24, 32'h1103_0005);
        wr(8'h28, 32'h0004_0201);
        wr(8'h2c, 32'h0002_0002);
        wr(8'h30, 32'h0000_0201);
        wr(8'h34, 32'h1102_0004);
        for (i = 0; i < 3; i++) period(i);
        for (i = 0; i < 3; i++) acq(0, trips[i]);
        for (i = 0; i < 2; i++) acq(1, i);
        wr(8'h24, 32'h1303_0005);
        acq(0, 2);
        // consensus lengths zero to six, six never met
        foreach (trips[i]) wr(8'h38, 32'h0008_0000 | (32'(trips[i] + 1 + i) << 28));
        for (i = 0; i < 7; i++)
        begin
            wr(8'h38, 32'h0008_0000 | (32'(i) << 28));
            acq(2, 2);
        end
        wr(8'h34, 32'h1302_0004);
        acq(2, 4);
        // x line spacing of 256 burst ticks between two matrix discharge starts
        wr(8'h34, 32'h0002_0004);
        wr(8'h38, 32'h0008_0100);
        acq(2, 2);
        r = dst;
        acq(2, 2);
        rng(dst - r, 510, 514);
        // recalibration threshold boundary
        wr(8'h1c, 32'h0010_0000);
        for (k = 15; k < 19; k++)
        begin
            r = $urandom & 32'h7fff;
            @(posedge i_clk);
            i_at_valid <= 1;
            i_at_reference <= 16'(r);
            i_at_signal <= 16'(r + k);
            @(posedge i_clk);
            i_at_valid <= 0;
            #1 chk(o_recal_req, k > 16);
        end
        // drift intervals of one and two units
        wr(8'h1c, 32'h0000_0102);
        @(posedge i_clk);
        i_at_sample_tick <= 1;
        n = 0;
        k = 0;
        while (o_pos_drift !== 1'b1)
        begin
            cyc();
            k += int'(o_neg_drift === 1'b1);
        end
        rng(n, 65536, 65537);
        chk(k, 32'h0000_0000);
        summarize();
    end
endmodule
